// file: logic/logger_pkg.sv
// Behaviour
// - Storage policy 0: stop writing when area full, keep counting measurements and time.
// - Storage policy 1: wrap to area start and bump 6-bit wrap count.
// - Limit violation counting is active in every logging format.
// - Four 8-bit counters: extreme upper, upper, lower, extreme lower violations.
// - The four counters are readable without memory readout.
// - Two-bit select picks compared sensor: temp, ext1, ext2, battery.
// - Interval timer runs from 1024 Hz tick, counted in seconds.
// - Interval supports values up to 65535 seconds; zero means 32768 seconds.
// - Delayed start is a 12-bit count in units of 512 seconds.
// - Delay loaded by initialize; counting starts only at begin-logging.
// - With delay disabled, a push button may start logging.
// - Converter result is 10 bits wide.
// - Each reference has its own 3-bit code in 50 mV steps from 160/260 mV.
// - References reset to 260 mV low and 410 mV high.
// - Grounding bit set connects the low reference to ground.
// - Battery code is 6 logged MSBs followed by four zero bits.
// - Interrupt-and-timer enable lets both timer and selected interrupts trigger logging.
package logger_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int OSC_HZ = 1024;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int DELAY_UNIT_S = 512;
    localparam int MAX_INTERVAL_S = 32768;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_AREA = 8'h0c;
    localparam logic [7:0] ADDR_LIMITS = 8'h10;
    localparam logic [7:0] ADDR_ADC = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_VIOL = 8'h20;
    localparam logic [7:0] ADDR_MEAS = 8'h24;

    // Control field positions.
    localparam int CTRL_STORE_POS = 0;
    localparam int CTRL_SEL_POS = 1;
    localparam int CTRL_IRQT_POS = 3;
    localparam int CTRL_EXT1_POS = 4;
    localparam int CTRL_EXT2_POS = 5;
    localparam int CTRL_DLYEN_POS = 6;
    // Command bits.
    localparam int CMD_START_POS = 0;
    localparam int CMD_END_POS = 1;
    localparam int CMD_CLRV_POS = 2;

    localparam logic [2:0] VLO_RESET = 3'h2;
    localparam logic [2:0] VHI_RESET = 3'h3;
    localparam logic [15:0] LOW_REF_BASE_MV = 16'h00a0;
    localparam logic [15:0] HIGH_REF_BASE_MV = 16'h0104;
    localparam logic [15:0] REF_STEP_MV = 16'h0032;

    localparam logic [1:0] SEL_TEMP = 2'h0;
    localparam logic [1:0] SEL_EXT1 = 2'h1;
    localparam logic [1:0] SEL_EXT2 = 2'h2;
    localparam logic [1:0] SEL_BATT = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_WAITBTN = 4'b0100,
        ST_LOG = 4'b1000
    } phase_t;

    typedef struct packed {
        logic [9:0] temp;
        logic [9:0] ext1;
        logic [9:0] ext2;
        logic [9:0] batt;
    } samples_t;

    typedef struct packed {
        logic valid;
        logic [9:0] data;
        logic [9:0] addr;
    } store_t;

    typedef struct packed {
        logic [7:0] ext_upper;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] ext_lower;
    } viol_t;
endpackage

// file: logic/sensor_data_logger_core.sv
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module sensor_data_logger_core
    import logger_pkg::*;
#(
    parameter int OSC_DIV_P = OSC_DIV,
    parameter int AREA_W = 10
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic button,
    input wire logic ext1_irq,
    input wire logic ext2_irq,
    input wire samples_t samples,
    output store_t store,
    output logic meas_req,
    output logic [2:0] adc_low_reference,
    output logic [2:0] adc_high_reference,
    output logic adc_low_gnd,
    output logic logging
);

    // The divider counter is 16 bits wide, so a larger division ratio cannot be served.
    if (OSC_DIV_P < 2 || OSC_DIV_P > 65536 || AREA_W < 1 || AREA_W > 16) begin : g_param_check
        $error("Unsupported parameter value.");
    end

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic store_wrap;
        logic [1:0] limit_sensor_select;
        logic irq_timer_en;
        logic ext1_en;
        logic ext2_en;
        logic delay_en;
        logic [15:0] interval;
        logic [11:0] delay_units;
        logic [15:0] area_start;
        logic [15:0] area_end;
        logic [9:0] lim_eu;
        logic [9:0] lim_u;
        logic [9:0] lim_l;
        logic [9:0] lim_el;
        logic [2:0] vlo;
        logic [2:0] vhi;
        logic gnd;
        phase_t phase;
        logic [15:0] div_cnt;
        logic [9:0] tick_cnt;
        logic [21:0] delay_sec;
        logic [16:0] sec_cnt;
        logic ext1_d;
        logic ext2_d;
        logic meas;
        logic meas_d;
        logic [15:0] wptr;
        logic full;
        logic [5:0] wrap_count;
        logic [15:0] meas_num;
        viol_t viol;
        store_t st;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
        sat_inc = (hit && v != 8'hff) ? v + 8'h01 : v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic req;
    logic wr;
    logic tick_1k;
    logic sec_pulse;
    logic trig_timer;
    logic trig_irq;
    logic [9:0] cmp_val;
    logic [31:0] ctrl_word;
    logic [31:0] wv;
    logic [31:0] m_interval;
    logic [31:0] m_delay;
    logic [31:0] m_area;
    logic [31:0] m_limits;

    always_comb begin
        req = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr = req && wb_we_i;
        tick_1k = (s_r.div_cnt == 16'(OSC_DIV_P - 1));
        sec_pulse = tick_1k && (s_r.tick_cnt == 10'(OSC_HZ - 1));
        ctrl_word = {25'h0, s_r.delay_en, s_r.ext2_en, s_r.ext1_en, s_r.irq_timer_en,
                     s_r.limit_sensor_select, s_r.store_wrap};
        wv = merge(32'h0, wb_dat_i, wb_sel_i);
        m_interval = merge({16'h0, s_r.interval}, wb_dat_i, wb_sel_i);
        m_delay = merge({20'h0, s_r.delay_units}, wb_dat_i, wb_sel_i);
        m_area = merge({s_r.area_end, s_r.area_start}, wb_dat_i, wb_sel_i);
        m_limits = merge({2'h0, s_r.lim_eu, s_r.lim_u, s_r.lim_l}, wb_dat_i, wb_sel_i);
        // An interval of zero is taken as 32768 seconds; written values reach 65535.
        trig_timer = sec_pulse && (s_r.sec_cnt + 17'h1 >=
                     ((s_r.interval == 16'h0) ? 17'(MAX_INTERVAL_S) : {1'b0, s_r.interval}));
        trig_irq = (s_r.ext1_en && ext1_irq && !s_r.ext1_d) || (s_r.ext2_en && ext2_irq && !s_r.ext2_d);
        unique case (s_r.limit_sensor_select)
            SEL_TEMP: cmp_val = samples.temp;
            SEL_EXT1: cmp_val = samples.ext1;
            SEL_EXT2: cmp_val = samples.ext2;
            SEL_BATT: cmp_val = {samples.batt[9:4], 4'h0};
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req;
        s_nxt.ext1_d = ext1_irq;
        s_nxt.ext2_d = ext2_irq;
        s_nxt.meas = 1'b0;
        s_nxt.meas_d = s_r.meas;
        s_nxt.st.valid = 1'b0;
        s_nxt.div_cnt = tick_1k ? 16'h0 : s_r.div_cnt + 16'h1;
        if (tick_1k) begin
            s_nxt.tick_cnt = (s_r.tick_cnt == 10'(OSC_HZ - 1)) ? 10'h0 : s_r.tick_cnt + 10'h1;
        end

        // Register reads.
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_CTRL: s_nxt.dat = ctrl_word;
                ADDR_INTERVAL: s_nxt.dat = {16'h0, s_r.interval};
                ADDR_DELAY: s_nxt.dat = {20'h0, s_r.delay_units};
                ADDR_AREA: s_nxt.dat = {s_r.area_end, s_r.area_start};
                ADDR_LIMITS: s_nxt.dat = {2'h0, s_r.lim_eu, s_r.lim_u, s_r.lim_l[9:0]};
                ADDR_ADC: s_nxt.dat = {14'h0, s_r.lim_el, 1'b0, s_r.gnd, s_r.vhi, s_r.vlo};
                ADDR_STATUS: s_nxt.dat = {16'h0, s_r.wptr[9:0], s_r.wrap_count};
                ADDR_VIOL: s_nxt.dat = s_r.viol;
                ADDR_MEAS: s_nxt.dat = {11'h0, s_r.full, s_r.phase, s_r.meas_num};
                default: s_nxt.dat = 32'h0;
            endcase
        end else if (req) begin
            s_nxt.dat = 32'h0;
        end

        // Register writes.
        if (wr) begin
            unique case (wb_adr_i)
                ADDR_CTRL: begin
                    s_nxt.store_wrap = wv[CTRL_STORE_POS];
                    s_nxt.limit_sensor_select = wv[CTRL_SEL_POS +: 2];
                    s_nxt.irq_timer_en = wv[CTRL_IRQT_POS];
                    s_nxt.ext1_en = wv[CTRL_EXT1_POS];
                    s_nxt.ext2_en = wv[CTRL_EXT2_POS];
                    s_nxt.delay_en = wv[CTRL_DLYEN_POS];
                end
                ADDR_INTERVAL: s_nxt.interval = m_interval[15:0];
                ADDR_DELAY: s_nxt.delay_units = m_delay[11:0];
                ADDR_AREA: {s_nxt.area_end, s_nxt.area_start} = m_area;
                ADDR_LIMITS: {s_nxt.lim_eu, s_nxt.lim_u, s_nxt.lim_l} = m_limits[29:0];
                ADDR_ADC: begin
                    s_nxt.vlo = wv[2:0];
                    s_nxt.vhi = wv[5:3];
                    s_nxt.gnd = wv[6];
                    s_nxt.lim_el = wv[17:8];
                end
                default: ;
            endcase
        end

        // Sequencing of start, delay and logging.
        unique case (s_r.phase)
            ST_IDLE: begin
                if (wr && wb_adr_i == ADDR_CMD && wv[CMD_START_POS]) begin
                    s_nxt.sec_cnt = 17'h0;
                    s_nxt.meas_num = 16'h0;
                    s_nxt.wptr = s_r.area_start;
                    s_nxt.full = 1'b0;
                    if (s_r.delay_en) begin
                        // 12-bit count of 512 s units, counted in seconds.
                        s_nxt.delay_sec = {s_r.delay_units, 10'h0} >> 1;
                        s_nxt.phase = ST_DELAY;
                    end else begin
                        s_nxt.phase = ST_WAITBTN;
                    end
                end
            end
            ST_DELAY: begin
                if (sec_pulse) begin
                    // Leaving on the pulse that reads one makes the delay exactly the loaded seconds.
                    if (s_r.delay_sec <= 22'h1) begin
                        s_nxt.phase = ST_LOG;
                    end else begin
                        s_nxt.delay_sec = s_r.delay_sec - 22'h1;
                    end
                end
            end
            ST_WAITBTN: begin
                if (button) begin
                    s_nxt.phase = ST_LOG;
                end
            end
            ST_LOG: begin
                if (sec_pulse) begin
                    s_nxt.sec_cnt = trig_timer ? 17'h0 : s_r.sec_cnt + 17'h1;
                end
                // Timer triggers unless a pure interrupt format is set without the combined enable.
                // A trigger right behind another is merged into it, so a request stays a single pulse.
                if (((trig_timer && (s_r.irq_timer_en || !(s_r.ext1_en || s_r.ext2_en))) ||
                     (trig_irq && (s_r.ext1_en || s_r.ext2_en))) && !s_r.meas) begin
                    s_nxt.meas = 1'b1;
                end
            end
            default: s_nxt.phase = ST_IDLE;
        endcase
        if (wr && wb_adr_i == ADDR_CMD && wv[CMD_END_POS]) begin
            s_nxt.phase = ST_IDLE;
            // A trigger in the ending cycle is dropped, so no request appears outside logging.
            s_nxt.meas = 1'b0;
        end

        // One cycle after the request, the sampled value is evaluated and stored.
        if (s_r.meas_d) begin
            s_nxt.meas_num = s_r.meas_num + 16'h1;
            s_nxt.viol.ext_upper = sat_inc(s_r.viol.ext_upper, cmp_val > s_r.lim_eu);
            s_nxt.viol.upper = sat_inc(s_r.viol.upper, cmp_val > s_r.lim_u);
            s_nxt.viol.lower = sat_inc(s_r.viol.lower, cmp_val < s_r.lim_l);
            s_nxt.viol.ext_lower = sat_inc(s_r.viol.ext_lower, cmp_val < s_r.lim_el);
            if (!s_r.full) begin
                s_nxt.st.valid = 1'b1;
                s_nxt.st.addr = s_r.wptr[9:0];
                s_nxt.st.data = samples.temp;
                if (s_r.wptr >= s_r.area_end) begin
                    if (s_r.store_wrap) begin
                        s_nxt.wptr = s_r.area_start;
                        s_nxt.wrap_count = s_r.wrap_count + 6'h1;
                    end else begin
                        s_nxt.full = 1'b1;
                    end
                end else begin
                    s_nxt.wptr = s_r.wptr + 16'h1;
                end
            end
        end
        if (wr && wb_adr_i == ADDR_CMD && wv[CMD_CLRV_POS]) begin
            s_nxt.viol = '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.phase <= ST_IDLE;
            s_r.vlo <= VLO_RESET;
            s_r.vhi <= VHI_RESET;
            s_r.area_end <= 16'h03ff;
            s_r.lim_eu <= 10'h3ff;
            s_r.lim_u <= 10'h3ff;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        wb_dat_o = s_r.dat;
        wb_ack_o = s_r.ack;
        store = s_r.st;
        meas_req = s_r.meas;
        adc_low_reference = s_r.vlo;
        adc_high_reference = s_r.vhi;
        adc_low_gnd = s_r.gnd;
        logging = s_r.phase == ST_LOG;
    end
endmodule

// file: test/logger_assertions.sv
`timescale 1ns/10ps
module logger_assertions
    import logger_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic button,
    input wire logic ext1_irq,
    input wire logic ext2_irq,
    input wire samples_t samples,
    input wire store_t store,
    input wire logic meas_req,
    input wire logic [2:0] adc_low_reference,
    input wire logic [2:0] adc_high_reference,
    input wire logic adc_low_gnd,
    input wire logic logging
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_REQ_PULSE: assert property (meas_req |=> !meas_req)
        else $error("measurement request longer than one cycle");
    AST_REQ_LOGGING: assert property (meas_req |-> logging)
        else $error("measurement outside the logging phase");
    AST_STORE_CAUSE: assert property (store.valid |-> $past(meas_req, 2))
        else $error("store without a measurement two cycles before");
    AST_STORE_DATA: assert property (store.valid |-> store.data == $past(samples.temp))
        else $error("stored data is not the captured temperature");
    // The references may only move on an acknowledged write, never on their own.
    AST_REF_WRITE: assert property (
        !$stable({adc_low_reference, adc_high_reference, adc_low_gnd}) |-> wb_ack_o && wb_we_i)
        else $error("converter reference changed without a write");
    COV_STORE: cover property (store.valid);
    COV_REQ: cover property (meas_req ##2 store.valid);
    COV_WRITE: cover property (wb_ack_o && wb_we_i);
endmodule
bind sensor_data_logger_core logger_assertions chk (
    .clock(clock),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .button(button),
    .ext1_irq(ext1_irq),
    .ext2_irq(ext2_irq),
    .samples(samples),
    .store(store),
    .meas_req(meas_req),
    .adc_low_reference(adc_low_reference),
    .adc_high_reference(adc_high_reference),
    .adc_low_gnd(adc_low_gnd),
    .logging(logging)
);

// file: test/sensor_data_logger_core_bench.sv
`timescale 1ns/10ps
module sensor_data_logger_core_bench;
    import logger_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic button = 1'b0;
    logic irq = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] q;
    logic [39:0] fresh = 40'h0;
    logic [31:0] dat_o;
    logic ack;
    logic meas_req;
    logic logging;
    logic gnd;
    logic [2:0] lo;
    logic [2:0] hi;
    logic [2:0] lo_e;
    logic [2:0] hi_e;
    samples_t samples;
    store_t store;
    int seed = 22388;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n, wp, wraps, k, t, v, cur_sel, policy, np, ll;
    int vc[4];
    logic full, mq = 1'b0, sc = 1'b0, ev = 1'b0;
    logic [9:0] ed, ea;

    always #25 clock = ~clock;

    sensor_data_logger_core #(.OSC_DIV_P(4)) dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .button(button), .ext1_irq(irq), .ext2_irq(irq), .samples(samples), .store(store),
        .meas_req(meas_req), .adc_low_reference(lo), .adc_high_reference(hi), .adc_low_gnd(gnd),
        .logging(logging));
    sensor_model sm (.clock(clock), .meas_req(meas_req), .fresh(fresh), .samples(samples));

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task end_sim;
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [7:0] sat8(input int c);
        return (c > 255) ? 8'hff : 8'(c);
    endfunction

    // Called right after a rising edge; returns one edge after the release so cyc stays low a cycle.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        fresh <= 40'({$random(seed), $random(seed)});
        cycles++;
        if (cycles > 90000) begin
            errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model: sampled on the falling edge so registered outputs have settled.
    always @(negedge clock) begin
        mq <= meas_req;
        sc <= mq;
        if (sc) begin
            chk("store valid", store.valid, ev);
            if (ev) chk("store word", {store.addr, store.data}, {ea, ed});
        end
        if (mq) begin
            v = samples[39 - 10 * cur_sel -: 10];
            if (cur_sel == 3) v = v & 'h3f0;
            vc[3] += (v > 'h380);
            vc[2] += (v > 'h300);
            vc[1] += (v < ll);
            vc[0] += (v < 'h080);
            n++;
            ev <= policy || !full;
            ed <= samples.temp;
            ea <= 10'(wp);
            if (policy || !full) begin
                if (wp == 4) begin
                    wp = policy ? 2 : 4;
                    wraps += policy;
                    full = !policy;
                end else wp++;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (k = 0; k < 4; k++) begin
            nrst <= 1'b0;
            repeat (16) @(posedge clock);
            nrst <= 1'b1;
            n = 0;
            wp = 2;
            wraps = 0;
            full = 1'b0;
            np = 0;
            vc = '{default: 0};
            cur_sel = k;
            policy = k % 2;
            // The last pass sets a lower limit that every battery code violates, to reach saturation.
            ll = (k == 3) ? 'h3ff : 'h100;
            if (k == 0) chk("reset refs", {lo, hi, gnd, logging}, {VLO_RESET, VHI_RESET, 2'h0});
            wb(0, 8'h3c, 32'h0);
            chk("unmapped", q, 32'h0);
            lo_e = 3'($random(seed));
            hi_e = 3'($random(seed));
            wb(1, ADDR_ADC, {14'h0, 10'h080, 1'b0, 1'(policy), hi_e, lo_e});
            chk("refs", {lo, hi, gnd}, {lo_e, hi_e, 1'(policy)});
            wb(1, ADDR_AREA, {16'h0004, 16'h0002});
            wb(1, ADDR_LIMITS, {2'h0, 10'h380, 10'h300, 10'(ll)});
            wb(1, ADDR_INTERVAL, 32'h1);
            wb(1, ADDR_DELAY, 32'h0);
            wb(1, ADDR_CTRL, {25'h0, k != 0, k == 3, k == 2, k == 3, 2'(k), 1'(policy)});
            wb(1, ADDR_CMD, 32'h1);
            if (k == 0) begin
                repeat (100) @(posedge clock);
                chk("idle before button", logging, 1'b0);
                button <= 1'b1;
                repeat (2) @(posedge clock);
                button <= 1'b0;
            end
            for (t = 0; logging !== 1'b1 && t < 9000; t++) @(posedge clock);
            chk("logging", logging, 1'b1);
            // Interrupt pulses drive both ext inputs in every pass while logging; they may trigger only in passes that enable an interrupt.
            while (n < ((k == 3) ? 270 : 4)) begin
                irq <= 1'b1;
                np++;
                @(posedge clock);
                irq <= 1'b0;
                repeat (20) @(posedge clock);
            end
            if (k == 2) chk("irq triggers", n, np);
            // A second spans 4096 cycles here, so timer-only runs see about 195 pulses per measurement.
            if (k < 2) chk("timer paced", np > 100 * (n - 1), 1'b1);
            wb(1, ADDR_CMD, 32'h2);
            repeat (5) @(posedge clock);
            wb(0, ADDR_VIOL, 32'h0);
            chk("violations", q, {sat8(vc[3]), sat8(vc[2]), sat8(vc[1]), sat8(vc[0])});
            wb(0, ADDR_MEAS, 32'h0);
            chk("meas count", q[15:0], 16'(n));
            if (policy == 0) chk("full", q[20], 1'b1);
            wb(0, ADDR_STATUS, 32'h0);
            if (policy == 1) chk("status", q[15:0], {10'(wp), 6'(wraps)});
        end
        end_sim();
    end
endmodule

// file: test/sensor_model.sv
`timescale 1ns/10ps
module sensor_model
    import logger_pkg::*;
(
    input wire logic clock,
    input wire logic meas_req,
    input wire logic [39:0] fresh,
    output samples_t samples
);
    initial samples = '0;
    // Results are valid only the cycle after a request; they churn otherwise to expose a late capture.
    always @(posedge clock) begin
        if (meas_req) begin
            // Battery low bits stay random so that the core must drop them itself.
            samples <= fresh;
        end else begin
            samples <= ~samples;
        end
    end
endmodule
